// *** logic/spiwbc_pkg.sv ***
package spiwbc_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h10;
  localparam logic [7:0] ADDR_DATA_LOW = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
  // Control register of our own: master, select output, enable, polarity
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_SEL_OE = 2;
  localparam int CTRL_CPOL = 3;
  localparam logic [7:0] CTRL_MASK = 8'h0f;
  // Control two fields and writable bits
  localparam int CR2_WIDTH = 6;
  localparam int CR2_MODE_FAULT_FLAG_EN = 4;
  localparam int CR2_BIDIR_OE = 3;
  localparam int CR2_PIN_BIDIR = 0;
  localparam logic [7:0] CR2_MASK = 8'h59;
  // Baud fields
  localparam int BR_PRE_LSB = 4;
  localparam int BR_SEL_LSB = 0;
  localparam logic [7:0] BR_MASK = 8'h77;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Status and interrupt bits
  localparam int ST_DONE = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_BUSY = 2;
  localparam logic [1:0] IRQ_MASK_BITS = 2'h3;
  typedef enum logic [1:0] {
    SPIWBC_IDLE = 2'b00,
    SPIWBC_RUN = 2'b01
  } spiwbc_state_t;
endpackage

// *** logic/spiwbc_top.sv ***
`timescale 1ns/10ps
module spiwbc_top (
  input wire logic sys_clk_in, // Bus clock 40 MHz
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB direction
  input wire logic [7:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error
  output logic irq_out, // Level interrupt
  output logic sck_out, // Serial clock out
  output logic sck_oe_n_out, // Serial clock enable, low drives
  input wire logic sck_in, // Serial clock in
  input wire logic mosi_in, // MOSI pin level
  output logic mosi_out, // MOSI drive value
  output logic mosi_oe_n_out, // MOSI enable, low drives
  input wire logic miso_in, // MISO pin level
  output logic miso_out, // MISO drive value
  output logic miso_oe_n_out, // MISO enable, low drives
  input wire logic ss_n_in, // Select pin level
  output logic ss_n_out, // Select drive value
  output logic ss_oe_n_out // Select enable, low drives
);
  import spiwbc_pkg::*;

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] cr2_ff, nxt_cr2;
  logic [7:0] br_ff, nxt_br;
  logic [15:0] tx_ff, nxt_tx;
  logic [15:0] sh_ff, nxt_sh;
  logic [15:0] rx_ff, nxt_rx;
  logic [1:0] ist_ff, nxt_ist;
  logic [1:0] imask_ff, nxt_imask;
  spiwbc_state_t st_ff, nxt_st;
  logic [10:0] div_ff, nxt_div;
  logic [4:0] edge_ff, nxt_edge;
  logic sck_ff, nxt_sck, rbit_ff, nxt_rbit;
  logic [31:0] prdata_ff, nxt_prdata;
  logic ready_ff, nxt_ready;
  logic err_ff, nxt_err;
  logic irq_ff, nxt_irq;
  logic [3:0] sync1_ff, sync2_ff;
  logic [2:0] sck_prev_ff;
  logic [6:0] pin_ff, nxt_pin;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  logic wr, rd, master, bidir, ss_s, sck_s, sck_edge, half_end;
  logic abort, fault, last_edge, sample;
  logic [7:0] cr2_new, br_new;
  logic [10:0] half_len;
  logic [4:0] frame_edges;

  assign wr = psel_in & penable_in & pwrite_in & ~ready_ff;
  assign rd = psel_in & penable_in & ~pwrite_in & ~ready_ff;
  assign master = ctrl_ff[CTRL_MASTER];
  assign bidir = cr2_ff[CR2_PIN_BIDIR];
  assign ss_s = sync2_ff[0];
  assign sck_s = sync2_ff[1];
  assign cr2_new = pwdata_in[7:0] & CR2_MASK;
  assign br_new = pwdata_in[7:0] & BR_MASK;
  assign half_len = 11'((({8'h00, br_ff[BR_PRE_LSB +: 3]} + 11'd1)
                    << br_ff[BR_SEL_LSB +: 3]) - 11'd1);
  assign frame_edges = cr2_ff[CR2_WIDTH] ? 5'd31 : 5'd15;
  assign half_end = div_ff == half_len;
  assign last_edge = edge_ff == frame_edges;
  assign sck_edge = sck_s ^ sck_prev_ff[0];
  // fault only when select is an input
  assign fault = master & cr2_ff[CR2_MODE_FAULT_FLAG_EN] & ~ctrl_ff[CTRL_SEL_OE] &
                 ~ss_s & ctrl_ff[CTRL_ENABLE];

  // Serial data input: pick pin by mode
  always_comb begin
    if (master) begin
      sample = bidir ? sync2_ff[2] : sync2_ff[3];
    end else begin
      sample = bidir ? sync2_ff[3] : sync2_ff[2];
    end
  end

  // Abort on any master-mode change of the steering fields
  always_comb begin
    abort = 1'b0;
    if (wr && master) begin
      // changed width, fault or pin bit
      if (is_addr(paddr_in, ADDR_CTRL_TWO) &&
          ((cr2_new[CR2_WIDTH] != cr2_ff[CR2_WIDTH]) ||
           (cr2_new[CR2_MODE_FAULT_FLAG_EN] != cr2_ff[CR2_MODE_FAULT_FLAG_EN]) ||
           (cr2_new[CR2_PIN_BIDIR] != cr2_ff[CR2_PIN_BIDIR]))) begin
        abort = 1'b1;
      end
      if (is_addr(paddr_in, ADDR_CTRL_TWO) && bidir &&
          (cr2_new[CR2_BIDIR_OE] != cr2_ff[CR2_BIDIR_OE])) begin
        abort = 1'b1;
      end
      if (is_addr(paddr_in, ADDR_BAUD) && (br_new != br_ff)) begin
        abort = 1'b1;
      end
    end
    if (wr && is_addr(paddr_in, ADDR_CTRL) &&
        ((pwdata_in[7:0] & CTRL_MASK) != ctrl_ff)) begin
      abort = 1'b1;
    end
    if (fault || !ctrl_ff[CTRL_ENABLE]) begin
      abort = 1'b1;
    end
  end

  // Register file and APB answer
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_cr2 = cr2_ff;
    nxt_br = br_ff;
    nxt_tx = tx_ff;
    nxt_imask = imask_ff;
    nxt_ready = wr | rd;
    nxt_err = 1'b0;
    nxt_prdata = prdata_ff;
    if (wr) begin
      unique case (paddr_in)
        ADDR_CTRL: nxt_ctrl = pwdata_in[7:0] & CTRL_MASK;
        ADDR_CTRL_TWO: nxt_cr2 = cr2_new;
        ADDR_BAUD: nxt_br = br_new;
        ADDR_DATA_HIGH: nxt_tx[15:8] = pwdata_in[7:0];
        ADDR_DATA_LOW: nxt_tx[7:0] = pwdata_in[7:0];
        ADDR_IRQ_MASK: nxt_imask = pwdata_in[1:0] & IRQ_MASK_BITS;
        ADDR_STATUS, ADDR_IRQ_STAT: nxt_err = 1'b0;
        default: nxt_err = 1'b1;
      endcase
    end
    if (rd) begin
      nxt_prdata = 32'h0000_0000;
      unique case (paddr_in)
        ADDR_CTRL: nxt_prdata[7:0] = ctrl_ff;
        ADDR_CTRL_TWO: nxt_prdata[7:0] = cr2_ff;
        ADDR_BAUD: nxt_prdata[7:0] = br_ff;
        ADDR_STATUS: nxt_prdata[2:0] = {st_ff == SPIWBC_RUN, ist_ff};
        // high byte unused in 8-bit mode
        ADDR_DATA_HIGH: nxt_prdata[7:0] = cr2_ff[CR2_WIDTH] ?
                                          rx_ff[15:8] : 8'h00;
        ADDR_DATA_LOW: nxt_prdata[7:0] = rx_ff[7:0];
        ADDR_IRQ_STAT: nxt_prdata[1:0] = ist_ff;
        ADDR_IRQ_MASK: nxt_prdata[1:0] = imask_ff;
        default: nxt_err = 1'b1;
      endcase
    end
  end

  // Transfer engine; master starts on a data low write
  always_comb begin
    nxt_st = st_ff;
    nxt_div = div_ff;
    nxt_edge = edge_ff;
    nxt_sck = sck_ff;
    nxt_sh = sh_ff;
    nxt_rbit = rbit_ff;
    nxt_rx = rx_ff;
    nxt_ist = ist_ff;
    if (wr && is_addr(paddr_in, ADDR_IRQ_STAT)) begin
      nxt_ist = ist_ff & ~pwdata_in[1:0];
    end
    unique case (st_ff)
      SPIWBC_IDLE: begin
        nxt_sck = ctrl_ff[CTRL_CPOL];
        nxt_div = 11'd0;
        nxt_edge = 5'd0;
        if (ctrl_ff[CTRL_ENABLE] && !abort) begin
          if (master && wr && is_addr(paddr_in, ADDR_DATA_LOW)) begin
            nxt_st = SPIWBC_RUN;
            // 8-bit frames sit in the top byte
            nxt_sh = cr2_ff[CR2_WIDTH] ? {tx_ff[15:8], pwdata_in[7:0]}
                                       : {pwdata_in[7:0], 8'h00};
          end else if (!master && !ss_s) begin
            // select is an input in slave mode
            nxt_st = SPIWBC_RUN;
            nxt_sh = cr2_ff[CR2_WIDTH] ? tx_ff : {tx_ff[7:0], 8'h00};
          end
        end
      end
      SPIWBC_RUN: begin
        if (master) begin
          nxt_div = half_end ? 11'd0 : 11'(div_ff + 11'd1);
          if (half_end) begin
            nxt_sck = ~sck_ff;
            nxt_edge = 5'(edge_ff + 5'd1);
            if (!edge_ff[0]) begin
              nxt_rbit = sample;
            end else begin
              nxt_sh = {sh_ff[14:0], rbit_ff};
            end
          end
        end else if (sck_edge) begin
          nxt_edge = 5'(edge_ff + 5'd1);
          if (!edge_ff[0]) begin
            nxt_rbit = sample;
          end else begin
            nxt_sh = {sh_ff[14:0], rbit_ff};
          end
        end
        if ((master ? half_end : sck_edge) && last_edge) begin
          nxt_st = SPIWBC_IDLE;
          nxt_rx = cr2_ff[CR2_WIDTH] ? nxt_sh : {8'h00, nxt_sh[7:0]};
          nxt_ist[ST_DONE] = 1'b1;
        end
        if (!master && ss_s) begin
          nxt_st = SPIWBC_IDLE;
        end
        // abort parks clock and clears counter
        if (abort) begin
          nxt_st = SPIWBC_IDLE;
          nxt_sck = ctrl_ff[CTRL_CPOL];
          nxt_edge = 5'd0;
          nxt_div = 11'd0;
        end
      end
      default: nxt_st = SPIWBC_IDLE;
    endcase
    // detection sets sticky fault; set wins over clear
    if (fault) begin
      nxt_ist[ST_FAULT] = 1'b1;
    end
    nxt_irq = |(nxt_ist & imask_ff);
  end

  // Pin drives: {sck_oe_n, ss_oe_n, ss, miso_oe_n, miso, mosi_oe_n, mosi}
  always_comb begin
    nxt_pin = 7'h7f;
    if (ctrl_ff[CTRL_ENABLE]) begin
      // select drive only with fault and output enable
      if (master && cr2_ff[CR2_MODE_FAULT_FLAG_EN] && ctrl_ff[CTRL_SEL_OE]) begin
        nxt_pin[5] = 1'b0;
        nxt_pin[4] = nxt_st != SPIWBC_RUN;
      end
      if (master) begin
        nxt_pin[6] = 1'b0;
        nxt_pin[1] = bidir & ~cr2_ff[CR2_BIDIR_OE];
        nxt_pin[0] = nxt_sh[15];
      end else begin
        nxt_pin[3] = ~((~bidir | cr2_ff[CR2_BIDIR_OE]) &
                       (nxt_st == SPIWBC_RUN));
        nxt_pin[2] = nxt_sh[15];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctrl_ff <= RESET_BYTE;
      cr2_ff <= RESET_BYTE;
      br_ff <= RESET_BYTE;
      tx_ff <= 16'h0000;
      sh_ff <= 16'h0000;
      rx_ff <= 16'h0000;
      ist_ff <= 2'h0;
      imask_ff <= 2'h0;
      st_ff <= SPIWBC_IDLE;
      div_ff <= 11'h000;
      edge_ff <= 5'h00;
      sck_ff <= 1'b0;
      rbit_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      irq_ff <= 1'b0;
      sync1_ff <= 4'hf;
      sync2_ff <= 4'hf;
      sck_prev_ff <= 3'h7;
      pin_ff <= 7'h7f;
    end else begin
      ctrl_ff <= nxt_ctrl;
      cr2_ff <= nxt_cr2;
      br_ff <= nxt_br;
      tx_ff <= nxt_tx;
      sh_ff <= nxt_sh;
      rx_ff <= nxt_rx;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      st_ff <= nxt_st;
      div_ff <= nxt_div;
      edge_ff <= nxt_edge;
      sck_ff <= nxt_sck;
      rbit_ff <= nxt_rbit;
      prdata_ff <= nxt_prdata;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
      irq_ff <= nxt_irq;
      // Raw pins cross here; master sampling lags two cycles, half period >= 3
      sync1_ff <= {miso_in, mosi_in, sck_in, ss_n_in};
      sync2_ff <= sync1_ff;
      sck_prev_ff <= {sck_prev_ff[1:0], sck_s};
      pin_ff <= nxt_pin;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = ready_ff;
  assign pslverr_out = err_ff;
  assign irq_out = irq_ff;
  assign sck_out = sck_ff;
  assign sck_oe_n_out = pin_ff[6];
  assign ss_oe_n_out = pin_ff[5];
  assign ss_n_out = pin_ff[4];
  assign miso_oe_n_out = pin_ff[3];
  assign miso_out = pin_ff[2];
  assign mosi_oe_n_out = pin_ff[1];
  assign mosi_out = pin_ff[0];
endmodule // spiwbc_top

// *** sim/spiwbc_peer.sv ***
`timescale 1ns/10ps
module spiwbc_peer (
  input wire logic sck_in, // Serial clock
  input wire logic mosi_in, // Data from master
  input wire logic act_in, // Frame active
  input wire logic [15:0] tx_in, // Reply word
  output logic miso_out, // Data to master
  output logic [15:0] rx_out // Received bits
);
  logic [15:0] sh;
  always @(posedge act_in) sh = tx_in;
  always @(posedge sck_in) if (act_in) rx_out = {rx_out[14:0], mosi_in};
  always @(negedge sck_in) if (act_in) sh = {sh[14:0], 1'b0};
  // Released line shows the inverse so a stale bit never passes
  assign miso_out = act_in ? sh[15] : ~sh[15];
endmodule // spiwbc_peer

// *** sim/spiwbc_assertions.sv ***
`timescale 1ns/10ps
module spiwbc_assertions
  import spiwbc_pkg::*;
(
  input wire logic sys_clk_in, // Bus clock
  input wire logic rst_n_in, // Reset
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB direction
  input wire logic [7:0] paddr_in, // APB address
  input wire logic [31:0] pwdata_in, // APB write data
  input wire logic [31:0] prdata_out, // APB read data
  input wire logic pready_out, // APB ready
  input wire logic pslverr_out, // APB error
  input wire logic mosi_oe_n_out, // MOSI enable
  input wire logic miso_oe_n_out, // MISO enable
  input wire logic ss_oe_n_out // Select enable
);
  logic [7:0] ctl_ff, cr2_ff;
  logic mst, bid, boe, mfe, take;
  // Shadows load on the edge the block takes the write
  assign take = psel_in && penable_in && pwrite_in && !pready_out;
  assign mst = ctl_ff[CTRL_MASTER];
  assign bid = cr2_ff[CR2_PIN_BIDIR];
  assign boe = cr2_ff[CR2_BIDIR_OE];
  assign mfe = cr2_ff[CR2_MODE_FAULT_FLAG_EN];
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctl_ff <= 8'h00;
      cr2_ff <= 8'h00;
    end else begin
      if (take && paddr_in == ADDR_CTRL) ctl_ff <= pwdata_in[7:0];
      if (take && paddr_in == ADDR_CTRL_TWO) cr2_ff <= pwdata_in[7:0];
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_err_ready; pslverr_out |-> pready_out; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_cr2_rsv; pready_out && !pwrite_in && paddr_in == ADDR_CTRL_TWO
    |-> !pslverr_out && (prdata_out & ~{24'h0, CR2_MASK}) == 32'h0; endproperty
  a_cr2_rsv: assert property (p_cr2_rsv)
    else $error("control two read bad");
  property p_br_rsv; pready_out && !pwrite_in && paddr_in == ADDR_BAUD
    |-> !pslverr_out && (prdata_out & ~{24'h0, BR_MASK}) == 32'h0; endproperty
  a_br_rsv: assert property (p_br_rsv)
    else $error("baud read bad");
  property p_mst_norm; (mst && !bid) [*3] |-> miso_oe_n_out; endproperty
  a_mst_norm: assert property (p_mst_norm)
    else $error("master drives miso");
  property p_mst_bidir; (mst && bid && !boe) [*3]
    |-> mosi_oe_n_out && miso_oe_n_out; endproperty
  a_mst_bidir: assert property (p_mst_bidir)
    else $error("master bidir drives");
  property p_slv_pins; (!mst) [*3]
    |-> mosi_oe_n_out && (!bid || boe || miso_oe_n_out); endproperty
  a_slv_pins: assert property (p_slv_pins)
    else $error("slave pin drive bad");
  property p_slv_sel; (!mst) [*3] |-> ss_oe_n_out; endproperty
  a_slv_sel: assert property (p_slv_sel)
    else $error("slave drives select");
  property p_mst_nofault; (mst && !mfe) [*3] |-> ss_oe_n_out; endproperty
  a_mst_nofault: assert property (p_mst_nofault)
    else $error("select used without enable");
endmodule // spiwbc_assertions

bind spiwbc_top spiwbc_assertions u_chk (.sys_clk_in, .rst_n_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .mosi_oe_n_out, .miso_oe_n_out, .ss_oe_n_out);

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import spiwbc_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ss_tb = 1, act = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, r;
  logic rdy, err, e1, irq, sck, sck_oen, mo, mo_oen, mi, mi_oen, ssn, ss_oen;
  logic pmi, ssv = 1;
  logic [15:0] ptx = 16'h0, prx;
  int fails = 0, checks_done = 0, cyc = 0;
  // Undriven lines: pull-up on MOSI, peer on MISO, bench on select
  wire mo_w = mo_oen ? 1'b1 : mo;
  wire mi_w = mi_oen ? pmi : mi;
  wire ss_w = ss_oen ? ss_tb : ssn;
  spiwbc_top dut (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(adr), .pwdata_in(wd),
    .prdata_out(rd), .pready_out(rdy), .pslverr_out(err), .irq_out(irq),
    .sck_out(sck), .sck_oe_n_out(sck_oen), .sck_in(1'b0), .mosi_in(mo_w),
    .mosi_out(mo), .mosi_oe_n_out(mo_oen), .miso_in(mi_w), .miso_out(mi),
    .miso_oe_n_out(mi_oen), .ss_n_in(ss_w), .ss_n_out(ssn),
    .ss_oe_n_out(ss_oen));
  spiwbc_peer peer (.sck_in(sck), .mosi_in(mo_w), .act_in(act), .tx_in(ptx),
    .miso_out(pmi), .rx_out(prx));
  initial forever #12.5 clk = ~clk;
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      test_done();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Half period in bus cycles: half of (prescaler+1) * 2^(select+1)
  function automatic int exp_hp(input logic [7:0] b);
    return ((int'(b[6:4]) + 1) * (2 << b[2:0])) / 2;
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    r = rd;
    e1 = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task edges(input int n, input int hp, output int e);
    int t;
    logic last;
    last = sck;
    t = 0;
    e = 0;
    repeat (n) begin
      @(posedge clk);
      t++;
      if (sck !== last) begin
        if (e > 0 && hp > 0) chk(t, hp);
        if (e == 2) ssv = ss_oen | ssn;
        e++;
        t = 0;
        last = sck;
      end
    end
  endtask
  task frame(input logic [15:0] d, input logic w16, input int hp);
    int e;
    ptx = 16'($urandom);
    act <= 1;
    if (w16) apb(1'b1, ADDR_DATA_HIGH, {24'h0, d[15:8]});
    apb(1'b1, ADDR_DATA_LOW, {24'h0, d[7:0]});
    edges(hp * 40 + 20, hp, e);
    chk(e, w16 ? 32 : 16);
    chk(mo_oen, 1'b0);
    chk(sck_oen, 1'b0);
    chk(prx & (w16 ? 16'hffff : 16'h00ff), w16 ? d : {8'h0, d[7:0]});
    apb(1'b0, ADDR_DATA_LOW, 0);
    chk(r, {24'h0, w16 ? ptx[7:0] : ptx[15:8]});
    if (w16) apb(1'b0, ADDR_DATA_HIGH, 0);
    if (w16) chk(r, {24'h0, ptx[15:8]});
    act <= 0;
  endtask
  initial begin
    int e, hp;
    logic [7:0] b;
    logic [31:0] w;
    void'($urandom(34));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(1'b0, ADDR_CTRL_TWO, 0);
    chk(r, 0);
    apb(1'b0, ADDR_BAUD, 0);
    chk(r, 0);
    for (int k = 0; k < 5; k++) begin
      w = (k == 0) ? 32'hffff_ffff : $urandom;
      apb(1'b1, ADDR_CTRL_TWO, w);
      apb(1'b1, ADDR_BAUD, ~w);
      apb(1'b0, ADDR_CTRL_TWO, 0);
      chk(r, w & CR2_MASK);
      apb(1'b0, ADDR_BAUD, 0);
      chk(r, ~w & BR_MASK);
    end
    apb(1'b0, 8'h20, 0);
    chk(e1, 1'b1);
    $display("test regs done");
    apb(1'b1, ADDR_CTRL, 32'h3);
    for (int k = 0; k < 6; k++) begin
      b = (k == 0) ? 8'h73 : (8'($urandom) & 8'h71) | 8'h02;
      hp = exp_hp(b);
      apb(1'b1, ADDR_BAUD, {24'h0, b});
      apb(1'b1, ADDR_CTRL_TWO, {25'h0, k[0], 6'h0});
      apb(1'b1, ADDR_IRQ_MASK, {31'h0, k[1]});
      frame(16'($urandom), k[0], hp);
      chk(irq, k[1]);
      apb(1'b1, ADDR_IRQ_STAT, 32'h3);
      chk(irq, 1'b0);
    end
    $display("test frames done");
    // Abort mid-frame by width, prescaler and bidir output enable
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, ADDR_CTRL_TWO, k == 2 ? 32'h1 : 32'h0);
      apb(1'b1, ADDR_BAUD, 32'h3);
      apb(1'b1, ADDR_IRQ_STAT, 32'h3);
      apb(1'b1, ADDR_DATA_LOW, 32'ha5);
      repeat (30) @(posedge clk);
      chk(mo_oen, k == 2);
      apb(1'b1, k == 1 ? ADDR_BAUD : ADDR_CTRL_TWO,
          k == 0 ? 32'h40 : (k == 1 ? 32'h13 : 32'h09));
      edges(200, 0, e);
      chk(mo_oen, 1'b0);
      chk(sck, 1'b0);
      chk(e, 0);
      apb(1'b0, ADDR_IRQ_STAT, 0);
      chk(r[ST_DONE], 1'b0);
    end
    $display("test aborts done");
    apb(1'b1, ADDR_BAUD, 32'h3);
    apb(1'b1, ADDR_CTRL_TWO, 32'h10);
    apb(1'b1, ADDR_CTRL, 32'h7);
    frame(16'h00c3, 1'b0, exp_hp(8'h03));
    chk(ssv, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_IRQ_STAT, 32'h3);
    ss_tb <= 0;
    repeat (6) @(posedge clk);
    apb(1'b0, ADDR_IRQ_STAT, 0);
    chk(r[ST_FAULT], 1'b1);
    apb(1'b1, ADDR_CTRL_TWO, 0);
    apb(1'b1, ADDR_IRQ_STAT, 32'h3);
    repeat (6) @(posedge clk);
    apb(1'b0, ADDR_IRQ_STAT, 0);
    chk(r[ST_FAULT], 1'b0);
    ss_tb <= 1;
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, ADDR_CTRL_TWO, k == 0 ? 0 : 32'h11 | ((k - 1) << 3));
      repeat (4) @(posedge clk);
      chk(ss_oen, 1'b1);
      chk(mo_oen, 1'b1);
      chk(sck_oen, 1'b1);
    end
    $display("test select done");
    test_done();
  end
endmodule // tb_top
